// ---- core/eepw_host.sv ----
// eepw_host: host-side controller for a byte-wide eeprom with
// software data protection and toggle-bit completion polling
// assumes the eeprom pins are driven straight from this block
//
// Summary of operation
// - each protected write (OP_PROT) is preceded by the unlock sequence.
// - unlock is three writes to fixed command addresses before data.
// - six command writes clear the nonvolatile protection.
// - command sequences run without any other access in between.
// - chip enable is the device select; strobes may be shared.
// - byte loads follow within 100 us of the previous strobe fall.
`timescale 1ns/1ps
module eepw_host #(
  parameter logic [19:0] WC_CYCLES = eepw_pkg::WC_CYC,
  parameter logic [47:0] UNLOCK_ADDR = 48'h3AAA_2555_3AAA,
  parameter logic [23:0] UNLOCK_DATA = 24'hA0_55_AA,
  parameter logic [95:0] RESET_ADDR = 96'h3AAA_3AAA_2555_3AAA_2555_3AAA,
  parameter logic [47:0] RESET_DATA = 48'h20_55_AA_80_55_AA
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // command port
  input wire logic cmdValid,
  input wire eepw_pkg::eepw_cmd_t cmd,
  output logic cmdReady,
  output logic rspValid,
  output eepw_pkg::eepw_rsp_t rsp,
  // supply sense
  input wire logic supplyOk,
  // eeprom pins
  output eepw_pkg::eepw_pins_t pins,
  input wire logic [7:0] pinDin
);
  eepw_pkg::eepw_state_t st_q, st_d;
  eepw_pkg::eepw_cmd_t cmd_q, cmd_d;
  eepw_pkg::eepw_pins_t pin_q, pin_d;
  eepw_pkg::eepw_rsp_t rsp_q, rsp_d;
  logic [2:0] idx_q, idx_d;
  logic [19:0] cnt_q, cnt_d;
  logic [19:0] gap_q, gap_d;
  logic prev_q, prev_d, have_q, have_d, stable_q, stable_d;
  logic rv_q, rv_d, rdy_q, rdy_d;
  logic [2:0] nWr;
  logic [15:0] wrAddr;
  logic [7:0] wrData;

  // number of writes and the source of each write's address and data
  always_comb begin
    wrAddr = cmd_q.addr;
    wrData = cmd_q.data;
    case (cmd_q.op)
      eepw_pkg::OP_WRITE: nWr = 3'h1;
      eepw_pkg::OP_PROT: nWr = eepw_pkg::UNLOCK_N + 3'h1;
      eepw_pkg::OP_UNPROT: nWr = eepw_pkg::RESET_N;
      default: nWr = 3'h0;
    endcase
    // unlock prefix before the data byte, which arms protection
    // prefix goes out on every protected write, whatever the device holds,
    // so the host keeps no copy of the nonvolatile state
    if (cmd_q.op == eepw_pkg::OP_PROT && idx_q < eepw_pkg::UNLOCK_N) begin
      wrAddr = UNLOCK_ADDR[idx_q * 16 +: 16];
      wrData = UNLOCK_DATA[idx_q * 8 +: 8];
    end else if (cmd_q.op == eepw_pkg::OP_UNPROT) begin
      wrAddr = RESET_ADDR[idx_q * 16 +: 16];
      wrData = RESET_DATA[idx_q * 8 +: 8];
    end
  end

  // sequencer next state
  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    pin_d = pin_q;
    rsp_d = rsp_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    prev_d = prev_q;
    have_d = have_q;
    stable_d = stable_q;
    rv_d = 1'b0;
    rdy_d = rdy_q;
    case (st_q)
      eepw_pkg::ST_IDLE: begin
        if (cmdValid && rdy_q) begin
          cmd_d = cmd;
          rdy_d = 1'b0;
          idx_d = 3'h0;
          have_d = 1'b0;
          stable_d = 1'b0;
          rsp_d.err = 1'b0;
          if (cmd.op == eepw_pkg::OP_READ) begin
            pin_d.addr = cmd.addr;
            pin_d.ceN = 1'b0;
            pin_d.oeN = 1'b0;
            cnt_d = 20'h00000;
            st_d = eepw_pkg::ST_RDACC;
          end else if (!supplyOk) begin
            rsp_d.err = 1'b1;
            rv_d = 1'b1;
            rdy_d = 1'b1;
          end else begin
            st_d = eepw_pkg::ST_SETUP;
          end
        end
      end
      eepw_pkg::ST_SETUP: begin
        // chip enable low, output enable high, data driven
        pin_d.addr = wrAddr;
        pin_d.dout = wrData;
        pin_d.doutOeN = 1'b0;
        pin_d.ceN = 1'b0;
        pin_d.oeN = 1'b1;
        cnt_d = 20'h00000;
        st_d = eepw_pkg::ST_STROBE;
      end
      eepw_pkg::ST_STROBE: begin
        pin_d.weN = 1'b0;
        cnt_d = cnt_q + 20'h00001;
        if (cnt_q == eepw_pkg::WE_CYC) begin
          pin_d.weN = 1'b1; // we rises first, data latched here
          st_d = eepw_pkg::ST_REL;
        end
      end
      eepw_pkg::ST_REL: begin
        pin_d.ceN = 1'b1;
        pin_d.doutOeN = 1'b1;
        idx_d = idx_q + 3'h1;
        have_d = 1'b0;
        stable_d = 1'b0;
        cnt_d = 20'h00000;
        // next write follows at once, no foreign access between
        if (idx_q + 3'h1 != nWr) begin
          st_d = eepw_pkg::ST_SETUP;
        end else if (cmd_q.op == eepw_pkg::OP_UNPROT) begin
          st_d = eepw_pkg::ST_WAIT;
        end else begin
          st_d = eepw_pkg::ST_RDEND;
        end
      end
      eepw_pkg::ST_RDACC: begin
        cnt_d = cnt_q + 20'h00001;
        if (cnt_q == eepw_pkg::RD_CYC) begin
          rsp_d.data = pinDin;
          prev_d = pinDin[eepw_pkg::TOGGLE_BIT];
          have_d = 1'b1;
          // toggle bit equal on two reads: programming finished
          stable_d = have_q && (prev_q == pinDin[eepw_pkg::TOGGLE_BIT]);
          pin_d.ceN = 1'b1;
          pin_d.oeN = 1'b1;
          st_d = eepw_pkg::ST_RDEND;
        end
      end
      eepw_pkg::ST_RDEND: begin
        if (cmd_q.op == eepw_pkg::OP_READ || stable_q) begin
          rv_d = 1'b1;
          rdy_d = 1'b1;
          st_d = eepw_pkg::ST_IDLE;
        end else begin
          pin_d.ceN = 1'b0;
          pin_d.oeN = 1'b0;
          cnt_d = 20'h00000;
          st_d = eepw_pkg::ST_RDACC;
        end
      end
      eepw_pkg::ST_WAIT: begin
        cnt_d = cnt_q + 20'h00001;
        if (cnt_q >= WC_CYCLES - 20'h00001) begin
          rv_d = 1'b1;
          rdy_d = 1'b1;
          st_d = eepw_pkg::ST_IDLE;
        end
      end
      default: st_d = eepw_pkg::ST_IDLE;
    endcase
  end

  // cycles since the last write strobe fall, cleared per command
  always_comb begin
    gap_d = (gap_q == 20'hFFFFF) ? gap_q : gap_q + 20'h00001;
    if (st_q == eepw_pkg::ST_IDLE || (!pin_d.weN && pin_q.weN)) begin
      gap_d = 20'h00000;
    end
  end

  // sequencer registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= eepw_pkg::ST_IDLE;
      cmd_q <= '0;
      pin_q <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: 16'h0000,
                 dout: 8'h00, doutOeN: 1'b1};
      rsp_q <= '0;
      idx_q <= 3'h0;
      cnt_q <= 20'h00000;
      gap_q <= 20'h00000;
      prev_q <= 1'b0;
      have_q <= 1'b0;
      stable_q <= 1'b0;
      rv_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      pin_q <= pin_d;
      rsp_q <= rsp_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      gap_q <= gap_d;
      prev_q <= prev_d;
      have_q <= have_d;
      stable_q <= stable_d;
      rv_q <= rv_d;
      rdy_q <= rdy_d;
    end
  end

  assign pins = pin_q;
  assign rsp = rsp_q;
  assign rspValid = rv_q;
  assign cmdReady = rdy_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence strobeLow;
    !pin_q.weN [*2] ##1 pin_q.weN;
  endsequence

  oneHot_state_a: assert property ($onehot(st_q))
    else $error("state not one-hot");
  weQual_a: assert property (!pin_q.weN |->
    !pin_q.ceN && pin_q.oeN && !pin_q.doutOeN)
    else $error("write strobe low with bad enables");
  weWidth_a: assert property ($fell(pin_q.weN) |-> strobeLow)
    else $error("write strobe pulse not two cycles");
  lockout_a: assert property (st_q == eepw_pkg::ST_IDLE && cmdValid &&
    rdy_q && cmd.op != eepw_pkg::OP_READ && !supplyOk
    |=> rspValid && rsp.err && pin_q.weN)
    else $error("write started under low supply");
  unlock_first_a: assert property (st_q == eepw_pkg::ST_IDLE &&
    cmdValid && rdy_q && cmd.op == eepw_pkg::OP_PROT && supplyOk
    |=> ##1 pin_q.addr == UNLOCK_ADDR[15:0] &&
    pin_q.dout == UNLOCK_DATA[7:0])
    else $error("unlock sequence not first");
  byte_gap_a: assert property ($fell(pin_q.weN) && idx_q != 3'h0
    |-> $past(gap_q) < eepw_pkg::LOAD_CYC) // count before this fall cleared it
    else $error("byte load gap too long");
  data_hold_a: assert property ($rose(pin_q.weN)
    |-> !pin_q.ceN && !pin_q.doutOeN)
    else $error("data or enable released before strobe rise");
  reset_wait_a: assert property (st_q == eepw_pkg::ST_WAIT &&
    cnt_q < WC_CYCLES - 20'h00001 |=> st_q == eepw_pkg::ST_WAIT)
    else $error("reset wait ended early");
  poll_done_a: assert property (rspValid && !rsp.err &&
    cmd_q.op inside {eepw_pkg::OP_WRITE, eepw_pkg::OP_PROT}
    |-> $past(stable_q))
    else $error("write done before toggle bit settled");
endmodule

// ---- core/eepw_pkg.sv ----
// eepw_pkg: constants and types for the eeprom write-protection host
// assumes a 10 MHz clock driving the eeprom pins directly
package eepw_pkg;
  localparam int CLK_NS = 100;
  localparam int WE_LOW_NS = 200;     // write strobe low time, far above glitch
  localparam int RD_ACC_NS = 250;     // read access wait
  localparam int BYTE_LOAD_US = 100;  // longest gap between byte loads
  localparam int WRITE_CYCLE_US = 5000;
  localparam logic [19:0] WE_CYC = 20'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [19:0] RD_CYC = 20'((RD_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [19:0] LOAD_CYC = 20'((BYTE_LOAD_US * 1000) / CLK_NS);
  localparam logic [19:0] WC_CYC = 20'((WRITE_CYCLE_US * 1000) / CLK_NS);
  localparam logic [2:0] UNLOCK_N = 3'h3;
  localparam logic [2:0] RESET_N = 3'h6;
  localparam int TOGGLE_BIT = 6;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_PROT = 2'h2,
    OP_UNPROT = 2'h3
  } eepw_op_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_SETUP = 7'h02,
    ST_STROBE = 7'h04,
    ST_REL = 7'h08,
    ST_RDACC = 7'h10,
    ST_RDEND = 7'h20,
    ST_WAIT = 7'h40
  } eepw_state_t;

  typedef struct packed {
    eepw_op_t op;
    logic [15:0] addr;
    logic [7:0] data;
  } eepw_cmd_t;

  typedef struct packed {
    logic err;
    logic [7:0] data;
  } eepw_rsp_t;

  typedef struct packed {
    logic ceN;
    logic oeN;
    logic weN;
    logic [15:0] addr;
    logic [7:0] dout;
    logic doutOeN;
  } eepw_pins_t;
endpackage

// ---- verif/eepw_dev_model.sv ----
// eepw_dev_model: behavioural byte-wide eeprom with software protection
// assumes pins come straight from eepw_host; no clock, edge driven
`timescale 1ns/1ps
module eepw_dev_model #(
  parameter logic [47:0] UNLOCK_ADDR = 48'h3AAA_2555_3AAA,
  parameter logic [23:0] UNLOCK_DATA = 24'hA0_55_AA,
  parameter logic [95:0] RESET_ADDR = 96'h3AAA_3AAA_2555_3AAA_2555_3AAA,
  parameter logic [47:0] RESET_DATA = 48'h20_55_AA_80_55_AA,
  parameter int BUSY_READS = 3
) (
  // strobes, address and data from the host
  input wire eepw_pkg::eepw_pins_t pins,
  // data bus back to the host
  output logic [7:0] pinDin
);
  logic [7:0] mem [logic [15:0]];
  logic [22:0] hist [6];
  logic [15:0] latA;
  logic [7:0] rd;
  logic armed = 1'b0; // factory state, kept until a protected write arms it
  logic winOpen = 1'b0;
  logic tog = 1'b0;
  int busy = 0;
  wire rdN = pins.ceN | pins.oeN; // chip enable is the select

  // recent writes compared against a command table, newest in slot 0
  // only an unbroken run of writes matches a command
  function automatic logic hit(input int n, input logic [95:0] a,
    input logic [47:0] d);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < n; k++)
      if (hist[n-1-k] !== {a[16*k +: 15], d[8*k +: 8]}) ok = 1'b0;
    return ok;
  endfunction

  // address taken as the strobe falls under a legal select
  always @(negedge pins.weN)
    if (!pins.ceN && pins.oeN) latA = pins.addr;

  // data taken as the strobe rises; address msb ignored for commands
  always @(posedge pins.weN) begin
    if (!pins.ceN && pins.oeN) begin
      for (int i = 5; i > 0; i--) hist[i] = hist[i-1];
      hist[0] = {latA[14:0], pins.dout};
      if (winOpen) begin
        mem[latA] = pins.dout;
        winOpen = 1'b0;
        armed = 1'b1;
        busy = BUSY_READS;
      end else if (hit(3, 96'(UNLOCK_ADDR), 48'(UNLOCK_DATA))) begin
        winOpen = 1'b1;
      end else if (hit(6, RESET_ADDR, RESET_DATA)) begin
        armed = 1'b0;
      end else if (!armed) begin
        mem[latA] = pins.dout;
        busy = BUSY_READS;
      end
    end
  end

  // each read start flips bit 6 while programming runs
  always @(negedge rdN) begin
    if (busy > 0) begin
      tog = ~tog;
      busy--;
    end
    rd = mem.exists(pins.addr) ? mem[pins.addr] : 8'hFF;
    if (busy > 0) rd[6] = tog;
    pinDin = rd;
  end

  // released bus never shows the last byte
  initial pinDin = 8'h00;
  always @(posedge rdN) pinDin = ~pinDin;
endmodule

// ---- verif/eepw_host_tb.sv ----
// eepw_host_tb: self-checking bench for the eeprom host controller
// assumes eepw_dev_model stands on the pins as the memory device
`timescale 1ns/1ps
module eepw_host_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmdValid = 1'b0;
  eepw_pkg::eepw_cmd_t cmd = '0;
  logic supplyOk = 1'b1;
  logic cmdReady;
  logic rspValid;
  eepw_pkg::eepw_rsp_t rsp;
  eepw_pkg::eepw_pins_t pins;
  logic [7:0] pinDin;
  logic [10:0] expQ [$];
  logic [10:0] e;
  int bad_count = 0;
  int check_count = 0;
  logic [15:0] a1;
  logic [7:0] d1;
  logic [7:0] d2;

  // 10 MHz clock
  always #50 clk = ~clk;

  eepw_host #(.WC_CYCLES(20'h00014)) u_eepw_host (.clk(clk),
    .arst_n(arst_n), .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady),
    .rspValid(rspValid), .rsp(rsp), .supplyOk(supplyOk), .pins(pins),
    .pinDin(pinDin));
  eepw_dev_model u_eepw_dev_model (.pins(pins), .pinDin(pinDin));

  // one comparison, counted
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // note the expectation, hand over one command, wait for its answer
  task automatic send(input eepw_pkg::eepw_op_t op, input logic [15:0] a,
    input logic [7:0] d, input logic [10:0] exp);
    int n;
    n = 0;
    expQ.push_back(exp);
    cmd = '{op, a, d};
    cmdValid = 1'b1;
    do begin
      @(posedge clk);
    end while (cmdReady !== 1'b1);
    #1 cmdValid = 1'b0;
    while (rspValid !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 3000) cmp(9'h1FF, 9'h000);
    @(posedge clk);
    #1;
  endtask

  // answer watcher: mode 1 full compare, mode 2 error flag only
  always @(posedge clk) begin
    if (rspValid === 1'b1) begin
      if (expQ.size() == 0) begin
        cmp(9'h1FF, 9'h000);
      end else begin
        e = expQ.pop_front();
        if (e[10:9] == 2'h1) cmp(rsp, e[8:0]);
        if (e[10:9] == 2'h2) cmp({8'h00, rsp.err}, {8'h00, e[8]});
      end
    end
  end

  // hang guard
  initial begin
    #3000000;
    bad_count++;
    report_and_stop();
  end

  // main sequence
  initial begin
    void'($urandom(32'hB520));
    a1 = 16'($urandom() & 32'h00007EFF);
    d1 = 8'($urandom());
    d2 = 8'($urandom());
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    cmp({5'h00, pins.ceN, pins.oeN, pins.weN, pins.doutOeN}, 9'h00F);
    send(eepw_pkg::OP_WRITE, a1, d1, {2'h1, 1'b0, d1});
    send(eepw_pkg::OP_READ, a1, 8'h00, {2'h1, 1'b0, d1});
    send(eepw_pkg::OP_PROT, a1 ^ 16'h0100, d2, {2'h1, 1'b0, d2});
    send(eepw_pkg::OP_READ, a1 ^ 16'h0100, 8'h00, {2'h1, 1'b0, d2});
    send(eepw_pkg::OP_WRITE, a1, ~d1, {2'h1, 1'b0, d1});
    send(eepw_pkg::OP_READ, a1, 8'h00, {2'h1, 1'b0, d1});
    send(eepw_pkg::OP_UNPROT, a1, 8'h00, {2'h2, 1'b0, 8'h00});
    send(eepw_pkg::OP_WRITE, a1, ~d1, {2'h1, 1'b0, ~d1});
    send(eepw_pkg::OP_READ, a1, 8'h00, {2'h1, 1'b0, ~d1});
    supplyOk = 1'b0;
    send(eepw_pkg::OP_WRITE, a1, d1, {2'h2, 1'b1, 8'h00});
    supplyOk = 1'b1;
    send(eepw_pkg::OP_READ, a1, 8'h00, {2'h1, 1'b0, ~d1});
    report_and_stop();
  end
endmodule
